// *** nand_host_ctrl.sv ***
// Overview of operation
// - five address cycles for read and program setup, column then row
// - latch and strobe levels select cycle type
// - host holds strobes high during read busy
// - read, program, erase use two-part commands
// - 05/E0 and 85 move column pointers
// - ECC status only right after page read
`timescale 1ns/1ps
module nand_host_ctrl #(
  parameter int ERASE_TIMEOUT = nand_host_pkg::ERASE_MAX_CYCLES,
  parameter int PROG_TIMEOUT  = nand_host_pkg::PROG_MAX_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             cmd_latch,
  output logic             addr_latch,
  output logic             chip_select_n,
  output logic             write_strobe_n,
  output logic             read_strobe_n,
  output logic             write_protect_n,
  input  wire logic [7:0]  shared_io_bus_in,
  output logic [7:0]       shared_io_bus_out,
  output logic             shared_io_bus_oe,
  input  wire logic        ready_busy_n
);
  import nand_host_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ISSUE = 3'b001,
    S_PIN   = 3'b010,
    S_WB    = 3'b011,
    S_RB    = 3'b100
  } seq_t;

  // address byte n of the five-cycle address
  function automatic logic [7:0] addr_byte(input logic [2:0] n,
                                           input logic [COL_W-1:0] col,
                                           input logic [ROW_W-1:0] row);
    logic [7:0] b;
    b = 8'h00;
    unique case (n)
      3'd0:    b = col[7:0];
      3'd1:    b = {4'h0, col[11:8]};
      3'd2:    b = row[7:0];
      3'd3:    b = row[15:8];
      default: b = {7'h00, row[16]};
    endcase
    return b;
  endfunction : addr_byte

  function automatic step_t mk(input kind_t k, input logic [7:0] d, input logic l);
    step_t s;
    s = '{kind: k, data: d, last: l};
    return s;
  endfunction : mk

  // pin-level step idx of each operation
  function automatic step_t step_of(input op_t op, input logic [2:0] idx,
                                    input logic [COL_W-1:0] col,
                                    input logic [ROW_W-1:0] row,
                                    input logic [7:0] wd);
    step_t s;
    s = mk(K_WAIT, 8'h00, 1'b1);
    unique case (op)
      OP_RESET:
        s = (idx == 3'd0) ? mk(K_CMD, CMD_RESET, 1'b0) : mk(K_WAIT, 8'h00, 1'b1);
      OP_STATUS:
        s = (idx == 3'd0) ? mk(K_CMD, CMD_STATUS, 1'b0) : mk(K_DOUT, 8'h00, 1'b1);
      OP_STATUS_DUAL:
        s = (idx == 3'd0) ? mk(K_CMD, CMD_STATUS_DUAL, 1'b0) : mk(K_DOUT, 8'h00, 1'b1);
      OP_READ: begin
        if (idx == 3'd0)      s = mk(K_CMD, CMD_READ_SETUP, 1'b0);
        else if (idx <= 3'd5) s = mk(K_ADDR, addr_byte(idx - 3'd1, col, row), 1'b0);
        else if (idx == 3'd6) s = mk(K_CMD, CMD_READ_GO, 1'b0);
        else                  s = mk(K_WAIT, 8'h00, 1'b1);
      end
      OP_PROG_SETUP: begin
        if (idx == 3'd0) s = mk(K_CMD, CMD_PROG_SETUP, 1'b0);
        else             s = mk(K_ADDR, addr_byte(idx - 3'd1, col, row), idx == 3'd5);
      end
      OP_PROG_GO:
        s = (idx == 3'd0) ? mk(K_CMD, CMD_PROG_GO, 1'b0) : mk(K_WAIT, 8'h00, 1'b1);
      OP_PROG_FIRST:
        s = (idx == 3'd0) ? mk(K_CMD, CMD_PROG_FIRST, 1'b0) : mk(K_WAIT, 8'h00, 1'b1);
      OP_ERASE: begin                            // row cycles only
        if (idx == 3'd0)      s = mk(K_CMD, CMD_ERASE_SETUP, 1'b0);
        else if (idx <= 3'd3) s = mk(K_ADDR, addr_byte(idx + 3'd1, col, row), 1'b0);
        else if (idx == 3'd4) s = mk(K_CMD, CMD_ERASE_GO, 1'b0);
        else                  s = mk(K_WAIT, 8'h00, 1'b1);
      end
      OP_COL_OUT: begin
        if (idx == 3'd0)      s = mk(K_CMD, CMD_COL_OUT, 1'b0);
        else if (idx <= 3'd2) s = mk(K_ADDR, addr_byte(idx - 3'd1, col, row), 1'b0);
        else                  s = mk(K_CMD, CMD_COL_OUT_GO, 1'b1);
      end
      OP_COL_IN: begin
        if (idx == 3'd0) s = mk(K_CMD, CMD_COL_IN, 1'b0);
        else             s = mk(K_ADDR, addr_byte(idx - 3'd1, col, row), idx == 3'd2);
      end
      OP_ECC:                                    // one byte per sector
        s = (idx == 3'd0) ? mk(K_CMD, CMD_ECC_STATUS, 1'b0)
                          : mk(K_DOUT, 8'h00, idx == 3'(ECC_SECTORS));
      OP_DATA_IN:  s = mk(K_DIN, wd, 1'b1);
      OP_DATA_OUT: s = mk(K_DOUT, 8'h00, 1'b1);
      default:     s = mk(K_WAIT, 8'h00, 1'b1);
    endcase
    return s;
  endfunction : step_of

  seq_t               seq, next_seq;
  op_t                op, next_op;
  logic [2:0]         idx, next_idx;
  logic [TIMER_W-1:0] timer, next_timer;
  logic [COL_W-1:0]   column, next_column;
  logic [ROW_W-1:0]   row, next_row;
  logic [7:0]         wdata, next_wdata;
  logic [31:0]        rdata, next_rdata;
  logic [7:0]         status_byte, next_status_byte;
  logic               wp_release, next_wp_release;
  logic               err, next_err, timed_out, next_timed_out;
  logic               ecc_ok, next_ecc_ok;
  logic               pin_start, next_pin_start;
  logic               next_ce_n;
  logic               next_wait;
  logic [31:0]        next_readdata;
  logic               wr_take;
  logic [3:0]         wr_op;
  logic               op_ok;
  logic [TIMER_W-1:0] limit;
  step_t              cur;
  logic [7:0]         pin_rx;
  logic               pin_done;

  assign cur     = step_of(op, idx, column, row, wdata);
  assign wr_take = avs_write && !avs_waitrequest;
  assign wr_op   = avs_writedata[CTRL_OP_LSB +: 4];
  // correction status read is refused unless it directly follows a page read
  assign op_ok   = (wr_op <= OP_LAST) && ((wr_op != OP_ECC) || ecc_ok);

  // busy wait bound per operation
  always_comb begin
    limit = TIMER_W'(PROG_TIMEOUT);
    if (op == OP_ERASE) limit = TIMER_W'(ERASE_TIMEOUT);
    if (op == OP_READ) limit = TIMER_W'(READ_MAX_CYCLES);
    if (op == OP_PROG_FIRST) limit = TIMER_W'(PROG_FIRST_CYCLES + WB_CYCLES);
  end

  // avalon slave: one wait cycle for reads and idle-time writes (writes wait while the sequencer runs), then a single cycle with waitrequest low
  always_comb begin
    next_wait     = 1'b1;
    next_readdata = avs_readdata;
    if (avs_waitrequest && (avs_read || (avs_write && seq == S_IDLE))) begin
      next_wait = 1'b0;
      unique case (avs_address)
        REG_CTRL:   next_readdata = {23'h0, wp_release, 4'h0, op};
        REG_COLUMN: next_readdata = {20'h0, column};
        REG_ROW:    next_readdata = {15'h0, row};
        REG_WDATA:  next_readdata = {24'h0, wdata};
        REG_RDATA:  next_readdata = rdata;
        REG_STATUS: next_readdata = {16'h0, status_byte, 3'h0, timed_out, ecc_ok, err,
                                     ready_busy_n, seq != S_IDLE};
        default:    next_readdata = 32'h0;
      endcase
    end
  end

  // sequencer and software registers
  always_comb begin
    next_seq         = seq;
    next_op          = op;
    next_idx         = idx;
    next_timer       = timer;
    next_column      = column;
    next_row         = row;
    next_wdata       = wdata;
    next_rdata       = rdata;
    next_status_byte = status_byte;
    next_wp_release  = wp_release;
    next_err         = err;
    next_timed_out   = timed_out;
    next_ecc_ok      = ecc_ok;
    next_pin_start   = 1'b0;
    if (wr_take) begin
      unique case (avs_address)
        REG_CTRL: begin
          next_wp_release = avs_writedata[CTRL_WP_BIT];
          if (op_ok) begin
            next_op     = op_t'(wr_op);
            next_idx    = 3'd0;
            next_seq    = S_ISSUE;
            next_ecc_ok = 1'b0;
          end else begin
            next_err = 1'b1;
          end
        end
        REG_COLUMN: next_column = avs_writedata[COL_W-1:0];
        REG_ROW:    next_row = avs_writedata[ROW_W-1:0];
        REG_WDATA:  next_wdata = avs_writedata[7:0];
        REG_STATUS: begin
          if (avs_writedata[ST_ERR]) next_err = 1'b0;
          if (avs_writedata[ST_TIMEOUT]) next_timed_out = 1'b0;
        end
        default: ;
      endcase
    end
    unique case (seq)
      S_IDLE: ;
      S_ISSUE: begin
        if (cur.kind == K_WAIT) begin
          next_timer = TIMER_W'(WB_CYCLES);
          next_seq   = S_WB;
        end else begin
          next_pin_start = 1'b1;
          next_seq       = S_PIN;
        end
      end
      S_PIN: begin
        if (pin_done) begin
          if (cur.kind == K_DOUT) begin
            next_rdata = {rdata[23:0], pin_rx};
            if (op == OP_STATUS || op == OP_STATUS_DUAL) next_status_byte = pin_rx;
          end
          next_idx = idx + 3'd1;
          next_seq = cur.last ? S_IDLE : S_ISSUE;
        end
      end
      S_WB: begin
        // ready/busy is not valid until the device had time to pull it low
        if (timer <= TIMER_W'(1)) begin
          next_timer = '0;
          next_seq   = S_RB;
        end else begin
          next_timer = timer - TIMER_W'(1);
        end
      end
      S_RB: begin
        // strobes stay high while waiting, chip select stays low
        if (ready_busy_n) begin
          next_seq = S_IDLE;
          if (op == OP_READ) next_ecc_ok = 1'b1;
        end else if (timer >= limit) begin
          next_seq       = S_IDLE;
          next_err       = 1'b1;
          next_timed_out = 1'b1;
        end else begin
          next_timer = timer + TIMER_W'(1);
        end
      end
      default: next_seq = S_IDLE;
    endcase
    // a hardware error raised in the clearing cycle survives the clear
    if (seq == S_RB && !ready_busy_n && timer >= limit) begin
      next_err       = 1'b1;
      next_timed_out = 1'b1;
    end
    next_ce_n = (next_seq == S_IDLE);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      seq             <= S_IDLE;
      op              <= OP_RESET;
      idx             <= 3'd0;
      timer           <= '0;
      column          <= COL_RESET;
      row             <= ROW_RESET;
      wdata           <= 8'h00;
      rdata           <= 32'h0;
      status_byte     <= 8'h00;
      wp_release      <= 1'b0;
      err             <= 1'b0;
      timed_out       <= 1'b0;
      ecc_ok          <= 1'b0;
      pin_start       <= 1'b0;
      chip_select_n   <= 1'b1;
      write_protect_n <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      seq             <= next_seq;
      op              <= next_op;
      idx             <= next_idx;
      timer           <= next_timer;
      column          <= next_column;
      row             <= next_row;
      wdata           <= next_wdata;
      rdata           <= next_rdata;
      status_byte     <= next_status_byte;
      wp_release      <= next_wp_release;
      err             <= next_err;
      timed_out       <= next_timed_out;
      ecc_ok          <= next_ecc_ok;
      pin_start       <= next_pin_start;
      chip_select_n   <= next_ce_n;
      write_protect_n <= next_wp_release;
      avs_waitrequest <= next_wait;
      avs_readdata    <= next_readdata;
    end
  end

  // one command, address, data-in or data-out bus cycle on the pins
  nand_pin_cycle u_pin (
    .clock          (clock),
    .srst           (srst),
    .start          (pin_start),
    .kind           (cur.kind),
    .tx_byte        (cur.data),
    .io_in          (shared_io_bus_in),
    .cmd_latch      (cmd_latch),
    .addr_latch     (addr_latch),
    .write_strobe_n (write_strobe_n),
    .read_strobe_n  (read_strobe_n),
    .io_out         (shared_io_bus_out),
    .io_oe          (shared_io_bus_oe),
    .rx_byte        (pin_rx),
    .done           (pin_done)
  );

endmodule : nand_host_ctrl

// *** nand_host_pkg.sv ***
package nand_host_pkg;

  // clock and derived timing
  localparam int CLK_NS           = 100;
  localparam int T_WB_NS          = 100;   // strobe high to busy, longest
  localparam int T_ERASE_MAX_US   = 5000;
  localparam int T_PROG_MAX_US    = 700;
  localparam int T_READ_MAX_US    = 200;   // dual-page array load, longest
  localparam int T_PROG_FIRST_US  = 1;     // short busy after first-page confirm
  // busy may appear up to the full window after the strobe, so wait one cycle past it
  localparam int WB_CYCLES        = (T_WB_NS + CLK_NS) / CLK_NS;
  localparam int ERASE_MAX_CYCLES = (T_ERASE_MAX_US * 1000) / CLK_NS;
  localparam int PROG_MAX_CYCLES  = (T_PROG_MAX_US * 1000) / CLK_NS;
  localparam int READ_MAX_CYCLES  = (T_READ_MAX_US * 1000) / CLK_NS;
  localparam int PROG_FIRST_CYCLES = (T_PROG_FIRST_US * 1000) / CLK_NS;

  // geometry
  localparam int COL_W        = 12;
  localparam int ROW_W        = 17;
  localparam int PAGE_BITS    = 6;
  localparam int PAGE_BYTES   = 2112;
  localparam int MAIN_BYTES   = 2048;
  localparam int SPARE_BYTES  = 64;
  localparam int PAGES_PER_BLK = 64;
  localparam int BLOCKS       = 2048;
  localparam int ECC_SECTORS  = 4;
  localparam int TIMER_W      = 17;

  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_COLUMN = 8'h04;
  localparam logic [7:0] REG_ROW    = 8'h08;
  localparam logic [7:0] REG_WDATA  = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // field positions
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_WP_BIT   = 8;
  localparam int ST_SEQ_BUSY   = 0;
  localparam int ST_RB         = 1;
  localparam int ST_ERR        = 2;
  localparam int ST_ECC_OK     = 3;
  localparam int ST_TIMEOUT    = 4;
  localparam int ST_BYTE_LSB   = 8;
  // device status byte
  localparam int SB_FAIL       = 0;
  localparam int SB_PLANE0     = 1;
  localparam int SB_PLANE1     = 2;
  localparam int SB_READY      = 6;
  localparam int SB_WP_N       = 7;

  // reset values
  localparam logic [COL_W-1:0] COL_RESET = 12'h000;
  localparam logic [ROW_W-1:0] ROW_RESET = 17'h00000;

  // device command codes
  localparam logic [7:0] CMD_READ_SETUP  = 8'h00;
  localparam logic [7:0] CMD_READ_GO     = 8'h30;
  localparam logic [7:0] CMD_PROG_SETUP  = 8'h80;
  localparam logic [7:0] CMD_PROG_GO     = 8'h10;
  localparam logic [7:0] CMD_PROG_FIRST  = 8'h11;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO    = 8'hd0;
  localparam logic [7:0] CMD_COL_OUT     = 8'h05;
  localparam logic [7:0] CMD_COL_OUT_GO  = 8'he0;
  localparam logic [7:0] CMD_COL_IN      = 8'h85;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_STATUS_DUAL = 8'h71;
  localparam logic [7:0] CMD_ECC_STATUS  = 8'h7a;
  localparam logic [7:0] CMD_RESET       = 8'hff;

  // software operations
  typedef enum logic [3:0] {
    OP_RESET       = 4'b0000,
    OP_STATUS      = 4'b0001,
    OP_STATUS_DUAL = 4'b0010,
    OP_READ        = 4'b0011,
    OP_PROG_SETUP  = 4'b0100,
    OP_PROG_GO     = 4'b0101,
    OP_PROG_FIRST  = 4'b0110,
    OP_ERASE       = 4'b0111,
    OP_COL_OUT     = 4'b1000,
    OP_COL_IN      = 4'b1001,
    OP_ECC         = 4'b1010,
    OP_DATA_IN     = 4'b1011,
    OP_DATA_OUT    = 4'b1100
  } op_t;
  localparam logic [3:0] OP_LAST = 4'hc;

  // one pin-level step
  typedef enum logic [2:0] {
    K_CMD  = 3'b000,
    K_ADDR = 3'b001,
    K_DIN  = 3'b010,
    K_DOUT = 3'b011,
    K_WAIT = 3'b100
  } kind_t;

  typedef struct packed {
    kind_t      kind;
    logic [7:0] data;
    logic       last;
  } step_t;

endpackage : nand_host_pkg

// *** nand_pin_cycle.sv ***
`timescale 1ns/1ps
module nand_pin_cycle (
  input  wire logic                 clock,
  input  wire logic                 srst,
  input  wire logic                 start,
  input  wire nand_host_pkg::kind_t kind,
  input  wire logic [7:0]           tx_byte,
  input  wire logic [7:0]           io_in,
  output logic                      cmd_latch,
  output logic                      addr_latch,
  output logic                      write_strobe_n,
  output logic                      read_strobe_n,
  output logic [7:0]                io_out,
  output logic                      io_oe,
  output logic [7:0]                rx_byte,
  output logic                      done
);
  import nand_host_pkg::*;

  typedef enum logic [1:0] {
    P_IDLE   = 2'b00,
    P_STROBE = 2'b01,
    P_HOLD   = 2'b10,
    P_GAP    = 2'b11
  } pin_t;

  pin_t       state, next_state;
  kind_t      kind_q, next_kind_q;
  logic       next_cle, next_ale, next_we_n, next_rd_n, next_oe, next_done;
  logic [7:0] next_io_out, next_rx;

  // every phase is one 100 ns cycle, which covers all strobe, setup and hold minima
  always_comb begin
    next_state  = state;
    next_kind_q = kind_q;
    next_cle    = cmd_latch;
    next_ale    = addr_latch;
    next_we_n   = write_strobe_n;
    next_rd_n   = read_strobe_n;
    next_oe     = io_oe;
    next_io_out = io_out;
    next_rx     = rx_byte;
    next_done   = 1'b0;
    unique case (state)
      P_IDLE: begin
        if (start) begin
          next_kind_q = kind;
          next_cle    = (kind == K_CMD);
          next_ale    = (kind == K_ADDR);
          if (kind == K_DOUT) begin
            next_rd_n = 1'b0;
          end else begin
            next_io_out = tx_byte;
            next_oe     = 1'b1;
            next_we_n   = 1'b0;
          end
          next_state = P_STROBE;
        end
      end
      P_STROBE: begin
        // rising write strobe latches command, address or data
        next_we_n = 1'b1;
        next_rd_n = 1'b1;
        if (kind_q == K_DOUT) begin
          next_rx = io_in;                 // sampled long after access time
        end
        next_state = P_HOLD;
      end
      P_HOLD: begin
        next_cle   = 1'b0;
        next_ale   = 1'b0;
        next_oe    = 1'b0;
        next_state = P_GAP;
      end
      P_GAP: begin
        // gap gives the turnaround between write and read strobes
        next_done  = 1'b1;
        next_state = P_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state          <= P_IDLE;
      kind_q         <= K_CMD;
      cmd_latch      <= 1'b0;
      addr_latch     <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n  <= 1'b1;
      io_oe          <= 1'b0;
      io_out         <= 8'h00;
      rx_byte        <= 8'h00;
      done           <= 1'b0;
    end else begin
      state          <= next_state;
      kind_q         <= next_kind_q;
      cmd_latch      <= next_cle;
      addr_latch     <= next_ale;
      write_strobe_n <= next_we_n;
      read_strobe_n  <= next_rd_n;
      io_oe          <= next_oe;
      io_out         <= next_io_out;
      rx_byte        <= next_rx;
      done           <= next_done;
    end
  end

endmodule : nand_pin_cycle

// *** nand_host_sva.sv ***
`timescale 1ns/1ps
module nand_host_sva (
  input wire logic clock,
  input wire logic srst,
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic shared_io_bus_oe,
  input wire logic ready_busy_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // bus side: single acknowledge, reads answered in the next cycle
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_READ_ANSWER: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read not answered");
  AST_WE_PULSE: assert property ($fell(write_strobe_n) |=> write_strobe_n)
    else $error("write strobe too long");
  AST_RE_PULSE: assert property ($fell(read_strobe_n) |=> read_strobe_n)
    else $error("read strobe too long");
  // latch must outlive the rising strobe, else the byte is lost
  AST_CMD_SEQ: assert property ($rose(cmd_latch) |-> !write_strobe_n ##1 write_strobe_n && cmd_latch ##1 !cmd_latch)
    else $error("command cycle shape wrong");
  AST_LATCH_HOLD: assert property ($rose(write_strobe_n) |-> $stable(addr_latch) && shared_io_bus_oe)
    else $error("latch or data moved at strobe rise");
  AST_WRITE_CYCLE: assert property (!write_strobe_n |-> !chip_select_n && shared_io_bus_oe && read_strobe_n && !(cmd_latch && addr_latch))
    else $error("bad write cycle levels");
  AST_READ_CYCLE: assert property (!read_strobe_n |-> !chip_select_n && !shared_io_bus_oe && !cmd_latch && !addr_latch)
    else $error("bad read cycle levels");
  AST_BUSY_QUIET: assert property (!ready_busy_n && !chip_select_n |-> write_strobe_n && read_strobe_n)
    else $error("strobe while device busy");
  AST_IDLE_QUIET: assert property (chip_select_n |-> write_strobe_n && read_strobe_n && !shared_io_bus_oe)
    else $error("activity while deselected");
  cover property ($fell(ready_busy_n));
  cover property ($fell(read_strobe_n));
  cover property ($rose(addr_latch));
endmodule : nand_host_sva

bind nand_host_ctrl nand_host_sva chk_u (.clock(clock), .srst(srst), .avs_read(avs_read),
  .avs_waitrequest(avs_waitrequest), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
  .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
  .read_strobe_n(read_strobe_n), .shared_io_bus_oe(shared_io_bus_oe), .ready_busy_n(ready_busy_n));

// *** nand_dev_model.sv ***
`timescale 1ns/1ps
module nand_dev_model (
  input  wire logic       cmd_latch,
  input  wire logic       addr_latch,
  input  wire logic       chip_select_n,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       write_protect_n,
  input  wire logic [7:0] io_in,
  output logic [7:0]      io_out,
  output logic            busy_pull
);
  logic [7:0]  cmd = 8'h00; // read setup preloaded at power-on
  logic [11:0] col = 12'h000;
  logic [16:0] row = 17'h00000;
  logic [2:0]  na = 3'h0;
  logic [1:0]  ecc_i = 2'h0;
  logic        fail = 1'b0;
  int          bt = 0;
  event        go;
  initial io_out = 8'h00;
  initial busy_pull = 1'b0;
  // open drain: pulled low for the whole operation
  always @(go) begin
    busy_pull = 1'b1;
    #(bt);
    busy_pull = 1'b0;
  end
  // capture on the write strobe rise; busy accepts only status and reset
  always @(posedge write_strobe_n) begin
    if (!chip_select_n && cmd_latch && (!busy_pull || io_in inside {8'h70, 8'h71, 8'hff})) begin
      cmd = io_in;
      na = 3'h0;
      ecc_i = 2'h0;
      case (io_in)
        8'h30: bt = 2000;
        8'h10: bt = 5000;
        8'hd0: bt = 10000;
        8'h11: bt = 500;
        8'hff: begin
          bt = 1000; // abort and recover
          fail = 1'b0;
        end
        default: bt = 0;
      endcase
      if (!write_protect_n && io_in inside {8'h10, 8'h11, 8'hd0}) begin
        fail = 1'b1;
        bt = 0;
      end
      if (bt > 0) ->go;
    end else if (!chip_select_n && addr_latch) begin
      case (na + ((cmd == 8'h60) ? 3'h2 : 3'h0)) // erase sends row bytes only
        3'h0: col[7:0] = io_in;
        3'h1: col[11:8] = io_in[3:0];
        3'h2: row[7:0] = io_in;
        3'h3: row[15:8] = io_in;
        default: row[16] = io_in[0];
      endcase
      na = na + 3'h1;
    end
  end
  // next byte on the falling read strobe, column advances on page data only
  always @(negedge read_strobe_n) begin
    if (!chip_select_n && !cmd_latch && !addr_latch && write_strobe_n) begin
      if (cmd inside {8'h70, 8'h71}) begin
        io_out = {write_protect_n, {2{!busy_pull}}, 3'h0, fail, fail};
      end else if (cmd == 8'h7a) begin
        io_out = 8'h10 + {6'h0, ecc_i}; // sector index as correction status
        if (ecc_i == 2'h3) cmd = 8'h30; // all four entries read, page output resumes
        ecc_i = ecc_i + 2'h1;
      end else begin
        io_out = col[7:0] ^ row[7:0]; // page bits live in the low row byte
        col = col + 12'h001;
      end
    end
  end
  // drivers off 25 ns after the rise; the floating bus then shows inverted data
  always @(posedge read_strobe_n) begin
    #25;
    io_out = ~io_out;
  end
endmodule : nand_dev_model

// *** tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module tb_top;
  import nand_host_pkg::*;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic        wp = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest, cle, ale, ce_n, we_n, rd_n, wp_n, h_oe, busy_pull;
  logic [7:0]  h_out, d_out, io_in;
  int          fails = 0;
  int          checked = 0;
  assign io_in = h_oe ? h_out : d_out; // host enable wins the shared bus
  always #50 clock = ~clock;
  nand_host_ctrl #(.ERASE_TIMEOUT(200), .PROG_TIMEOUT(100)) dut_u (.clock(clock), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmd_latch(cle), .addr_latch(ale), .chip_select_n(ce_n), .write_strobe_n(we_n),
    .read_strobe_n(rd_n), .write_protect_n(wp_n), .shared_io_bus_in(io_in),
    .shared_io_bus_out(h_out), .shared_io_bus_oe(h_oe), .ready_busy_n(!busy_pull));
  nand_dev_model dev_u (.cmd_latch(cle), .addr_latch(ale), .chip_select_n(ce_n),
    .write_strobe_n(we_n), .read_strobe_n(rd_n), .write_protect_n(wp_n), .io_in(io_in),
    .io_out(d_out), .busy_pull(busy_pull));
  // hold the request until waitrequest is seen low, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // start an operation and poll until the sequencer is idle
  task automatic op(input logic [3:0] c);
    bus(1'b1, REG_CTRL, {23'h0, wp, 4'h0, c});
    repeat (3) @(posedge clock);
    do bus(1'b0, REG_STATUS, 32'h0); while (q[ST_SEQ_BUSY] !== 1'b0);
  endtask : op
  task automatic addr(input logic [11:0] c, input logic [16:0] r);
    bus(1'b1, REG_COLUMN, {20'h0, c});
    bus(1'b1, REG_ROW, {15'h0, r});
  endtask : addr
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    #3000000;
    fails++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    bus(1'b0, REG_CTRL, 32'h0); `CHK(q, 32'h0)
    bus(1'b0, 8'h20, 32'h0); `CHK(q, 32'h0)
    op(OP_STATUS); bus(1'b0, REG_STATUS, 32'h0); `CHK(q[15:8], 8'h60)
    addr(12'h000, 17'h00040); op(OP_PROG_SETUP); bus(1'b1, REG_WDATA, 32'h5a);
    op(OP_DATA_IN); op(OP_PROG_GO); op(OP_STATUS);
    bus(1'b0, REG_STATUS, 32'h0); `CHK(q[15:8], 8'h63)
    op(OP_RESET); wp = 1'b1; op(OP_STATUS);
    bus(1'b0, REG_STATUS, 32'h0); `CHK(q[15:8], 8'he0)
    addr(12'h7ff, 17'h0007f); op(OP_PROG_SETUP); `CHK(dev_u.row, 17'h0007f)
    `CHK(dev_u.col, 12'h7ff)
    addr(12'h010, 17'h0007f); op(OP_COL_IN); `CHK(dev_u.col, 12'h010)
    op(OP_DATA_IN); op(OP_PROG_GO); bus(1'b0, REG_STATUS, 32'h0); `CHK(q[4:2], 3'b000)
    op(OP_PROG_SETUP); op(OP_PROG_FIRST); op(OP_STATUS_DUAL); bus(1'b0, REG_STATUS, 32'h0);
    `CHK({q[15:8], q[4:2]}, {8'he0, 3'b000})
    addr(12'h000, 17'h1ffc0); op(OP_ERASE); `CHK(dev_u.row, 17'h1ffc0)
    bus(1'b0, REG_STATUS, 32'h0); `CHK({dev_u.cmd, q[4:2]}, {8'hd0, 3'b000})
    addr(12'h123, 17'h10041); op(OP_READ); `CHK(dev_u.cmd, 8'h30)
    bus(1'b0, REG_STATUS, 32'h0); `CHK(q[ST_ECC_OK], 1'b1)
    op(OP_ECC); bus(1'b0, REG_RDATA, 32'h0); `CHK(q, 32'h10111213)
    op(OP_DATA_OUT); op(OP_DATA_OUT); bus(1'b0, REG_RDATA, 32'h0); `CHK(q[15:0], 16'h6265)
    addr(12'h800, 17'h10041); op(OP_COL_OUT); op(OP_DATA_OUT);
    bus(1'b0, REG_RDATA, 32'h0); `CHK(q[7:0], 8'h41)
    op(OP_ECC); bus(1'b0, REG_STATUS, 32'h0); `CHK(q[ST_ERR], 1'b1)
    bus(1'b1, REG_STATUS, 32'h4); bus(1'b0, REG_STATUS, 32'h0); `CHK(q[ST_ERR], 1'b0)
    tally_and_finish;
  end
endmodule : tb_top
